// File: core/iop_fifo.sv
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/100ps
module iop_fifo
    import iop_pkg::*;
#(
    parameter int unsigned W = 8,
    parameter int unsigned D = FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rstn_i,
    // Fill side
    input  wire logic wvalid_i,
    output logic wready_o,
    input  wire logic [W-1:0] wdata_i,
    // Drain side
    output logic rvalid_o,
    input  wire logic rready_i,
    output logic [W-1:0] rdata_o
);
    localparam int unsigned AW = (D > 1) ? $clog2(D) : 1;
    localparam logic [AW:0] DEPTH_C = (AW + 1)'(D);
    localparam logic [AW-1:0] LAST_C = AW'(D - 1);

    logic [W-1:0] mem_q [D];
    logic [AW-1:0] wptr_q, wptr_d, rptr_q, rptr_d;
    logic [AW:0] count_q, count_d;
    logic push, pop;

    // ------------------------------------------------------------
    // Pointers and level
    // ------------------------------------------------------------
    assign wready_o = (count_q != DEPTH_C);
    assign rvalid_o = (count_q != '0);
    assign rdata_o = mem_q[rptr_q];
    assign push = wvalid_i && wready_o;
    assign pop = rvalid_o && rready_i;

    always_comb begin
        wptr_d = wptr_q;
        rptr_d = rptr_q;
        count_d = count_q;
        if (push) begin
            wptr_d = (wptr_q == LAST_C) ? '0 : wptr_q + 1'b1;
        end
        if (pop) begin
            rptr_d = (rptr_q == LAST_C) ? '0 : rptr_q + 1'b1;
        end
        if (push && !pop) begin
            count_d = count_q + 1'b1;
        end else if (pop && !push) begin
            count_d = count_q - 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wptr_q <= '0;
            rptr_q <= '0;
            count_q <= '0;
        end else begin
            wptr_q <= wptr_d;
            rptr_q <= rptr_d;
            count_q <= count_d;
        end
    end

    // Storage has no reset; only written entries are ever read
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wptr_q] <= wdata_i;
        end
    end

endmodule

// File: core/iop_pkg.sv
// Shared constants and types of the programmable I/O port
package iop_pkg;

    // ------------------------------------------------------------
    // Clock blocks
    // ------------------------------------------------------------
    localparam int unsigned NUM_CLKBLK = 6;
    localparam logic [2:0] CLKBLK_RESET = 3'h0;
    localparam logic [7:0] CLKDIV_RESET = 8'h00;

    // ------------------------------------------------------------
    // Counter, FIFO and synchroniser
    // ------------------------------------------------------------
    localparam int unsigned CNT_W = 16;
    localparam logic [15:0] CNT_RESET = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hffff;
    localparam int unsigned FIFO_DEPTH = 16;
    localparam int unsigned SYNC_STAGES = 3;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        COND_NONE = 2'b00,
        COND_EQ   = 2'b01,
        COND_NEQ  = 2'b10
    } iop_cond_t;

    typedef enum logic [1:0] {
        ST_IDLE      = 2'b00,
        ST_WAIT_TIME = 2'b01,
        ST_WAIT_COND = 2'b10,
        ST_SHIFT     = 2'b11
    } iop_state_t;

    typedef struct packed {
        logic enable;
        logic dir_out;
        logic open_coll;
        iop_cond_t cond;
        logic strobe_in_en;
        logic strobe_out_en;
        logic [2:0] clk_sel;
        logic timed;
        logic [15:0] target;
    } iop_cfg_t;

    typedef struct packed {
        logic ext_src;
        logic [7:0] div;
    } iop_clkblk_cfg_t;

endpackage

// File: core/iop_port.sv
// Programmable I/O port: pin mux, SERDES, port counter and clock blocks
`timescale 1ns/100ps
module iop_port
    import iop_pkg::*;
#(
    parameter int unsigned WIDTH = 4,
    parameter int unsigned RATIO = 2,
    parameter logic [WIDTH-1:0] LINK_MASK = '1
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rstn_i,
    // Configuration
    input  wire iop_cfg_t cfg_i,
    input  wire logic [WIDTH-1:0] cond_value_i,
    input  wire iop_clkblk_cfg_t [NUM_CLKBLK-1:0] clkblk_cfg_i,
    input  wire logic link_en_i,
    input  wire logic [WIDTH-1:0] narrow_taken_i,
    // Core output data
    input  wire logic out_valid_i,
    output logic out_ready_o,
    input  wire logic [WIDTH*RATIO-1:0] out_data_i,
    // Core input data
    output logic in_valid_o,
    input  wire logic in_ready_i,
    output logic [WIDTH*RATIO-1:0] in_data_o,
    // Core status
    output logic [CNT_W-1:0] cnt_o,
    output logic [CNT_W-1:0] tstamp_o,
    output logic event_o,
    // Pins
    input  wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] pin_o,
    output logic [WIDTH-1:0] pin_oe_n_o,
    input  wire logic ext_clk_i,
    input  wire logic input_strobe_i,
    output logic output_strobe_o
);
    localparam int unsigned XW = WIDTH * RATIO;
    localparam int unsigned BW = (RATIO > 1) ? $clog2(RATIO) : 1;
    localparam int unsigned SW = WIDTH + 2;
    localparam logic [BW-1:0] LAST_BEAT = BW'(RATIO - 1);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [SW-1:0] s1_q, s2_q, s3_q, stab_q, stab_d;
    logic [WIDTH-1:0] pin_s;
    logic ext_clk_s, strobe_s, ext_clk_prev_q, ext_rise;

    // Change counts only once second and third stage agree
    always_comb begin
        stab_d = (s2_q & ~(s2_q ^ s3_q)) | (stab_q & (s2_q ^ s3_q));
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            stab_q <= '0;
            ext_clk_prev_q <= 1'b0;
        end else begin
            s1_q <= {ext_clk_i, input_strobe_i, pin_i};
            s2_q <= s1_q;
            s3_q <= s2_q;
            stab_q <= stab_d;
            ext_clk_prev_q <= ext_clk_s;
        end
    end

    assign pin_s = stab_q[WIDTH-1:0];
    assign strobe_s = stab_q[WIDTH];
    assign ext_clk_s = stab_q[WIDTH+1];
    assign ext_rise = ext_clk_s && !ext_clk_prev_q;

    // ------------------------------------------------------------
    // Clock blocks
    // ------------------------------------------------------------
    logic [NUM_CLKBLK-1:0] tick;
    logic [2:0] sel_q;
    logic sel_tick;

    assign tick[0] = 1'b1;

    for (genvar g = 1; g < NUM_CLKBLK; g++) begin : g_clkblk
        logic [7:0] div_q, div_d;
        logic src, tick_q, tick_d;
        always_comb begin
            src = clkblk_cfg_i[g].ext_src ? ext_rise : 1'b1;
            div_d = div_q;
            tick_d = 1'b0;
            if (src) begin
                if (div_q >= clkblk_cfg_i[g].div) begin
                    div_d = '0;
                    tick_d = 1'b1;
                end else begin
                    div_d = div_q + 1'b1;
                end
            end
        end
        always_ff @(posedge clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
                div_q <= CLKDIV_RESET;
                tick_q <= 1'b0;
            end else begin
                div_q <= div_d;
                tick_q <= tick_d;
            end
        end
        assign tick[g] = tick_q;
    end

    // Out-of-range selections fall back to the reference block
    assign sel_tick = (sel_q < 3'(NUM_CLKBLK)) ? tick[sel_q] : tick[0];

    // ------------------------------------------------------------
    // Port counter
    // ------------------------------------------------------------
    logic [CNT_W-1:0] cnt_q, cnt_d;

    always_comb begin
        cnt_d = sel_tick ? cnt_q + 1'b1 : cnt_q;
    end

    // ------------------------------------------------------------
    // FIFO between core and SERDES
    // ------------------------------------------------------------
    logic f_wvalid, f_wready, f_rvalid, f_rready;
    logic [XW-1:0] f_wdata, f_rdata;
    logic push_q, push_d;
    logic [XW-1:0] hold_q, hold_d;
    logic pop;

    // One FIFO serves whichever direction the port is set to
    assign f_wvalid = cfg_i.dir_out ? out_valid_i : push_q;
    assign f_wdata = cfg_i.dir_out ? out_data_i : hold_q;
    assign f_rready = cfg_i.dir_out ? pop : in_ready_i;
    assign out_ready_o = cfg_i.dir_out && f_wready;
    assign in_valid_o = !cfg_i.dir_out && f_rvalid;
    assign in_data_o = f_rdata;

    iop_fifo #(
        .W(XW),
        .D(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .wvalid_i(f_wvalid),
        .wready_o(f_wready),
        .wdata_i(f_wdata),
        .rvalid_o(f_rvalid),
        .rready_i(f_rready),
        .rdata_o(f_rdata)
    );

    // ------------------------------------------------------------
    // Transfer state machine and SERDES
    // ------------------------------------------------------------
    iop_state_t state_q, state_d;
    logic [XW-1:0] sh_q, sh_d;
    logic [BW-1:0] beat_q, beat_d;
    logic [WIDTH-1:0] drv_q, drv_d, owned;
    logic [WIDTH-1:0] oe_n_d;
    logic [CNT_W-1:0] ts_q, ts_d;
    logic ev_d, ev_q, ostb_d, ostb_q, cond_met, strobe_ok, time_ok;

    assign owned = cfg_i.enable ? ~narrow_taken_i
        & ~(link_en_i ? LINK_MASK : '0) : '0;
    assign cond_met = (cfg_i.cond == COND_EQ) ? (pin_s == cond_value_i)
        : (pin_s != cond_value_i);
    assign strobe_ok = !cfg_i.strobe_in_en || strobe_s;
    assign time_ok = sel_tick && (cnt_q == cfg_i.target);
    assign pop = (state_q == ST_IDLE) && cfg_i.enable && cfg_i.dir_out && f_rvalid;

    always_comb begin
        state_d = state_q;
        sh_d = sh_q;
        beat_d = beat_q;
        drv_d = drv_q;
        ts_d = ts_q;
        push_d = push_q && !f_wready;
        hold_d = hold_q;
        ev_d = 1'b0;
        ostb_d = 1'b0;
        case (state_q)
            ST_IDLE: begin
                beat_d = '0;
                if (pop) begin
                    sh_d = f_rdata;
                    state_d = cfg_i.timed ? ST_WAIT_TIME : ST_SHIFT;
                end else if (cfg_i.enable && !cfg_i.dir_out && !push_q) begin
                    if (cfg_i.cond != COND_NONE) begin
                        state_d = ST_WAIT_COND;
                    end else begin
                        state_d = cfg_i.timed ? ST_WAIT_TIME : ST_SHIFT;
                    end
                end
            end
            ST_WAIT_TIME: begin
                if (time_ok) begin
                    state_d = ST_SHIFT;
                end
            end
            ST_WAIT_COND: begin
                if (sel_tick && cond_met) begin
                    ev_d = 1'b1;
                    state_d = cfg_i.timed ? ST_WAIT_TIME : ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (sel_tick && (cfg_i.dir_out || strobe_ok)) begin
                    if (beat_q == '0) begin
                        ts_d = cnt_q;
                    end
                    if (cfg_i.dir_out) begin
                        drv_d = sh_q[WIDTH-1:0];
                        ostb_d = cfg_i.strobe_out_en;
                        sh_d = XW'(sh_q >> WIDTH);
                    end else begin
                        sh_d = {pin_s & owned, sh_q[XW-1:WIDTH]};
                    end
                    beat_d = beat_q + 1'b1;
                    if (beat_q == LAST_BEAT) begin
                        state_d = ST_IDLE;
                        if (!cfg_i.dir_out) begin
                            hold_d = {pin_s & owned, sh_q[XW-1:WIDTH]};
                            push_d = 1'b1;
                        end
                    end
                end
                if (!cfg_i.enable) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        for (int i = 0; i < WIDTH; i++) begin
            // Open collector never drives a one
            oe_n_d[i] = !(owned[i] && cfg_i.dir_out
                && !(cfg_i.open_coll && drv_d[i]));
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q <= ST_IDLE;
            sh_q <= '0;
            beat_q <= '0;
            drv_q <= '0;
            ts_q <= CNT_RESET;
            push_q <= 1'b0;
            hold_q <= '0;
            ev_q <= 1'b0;
            ostb_q <= 1'b0;
            cnt_q <= CNT_RESET;
            sel_q <= CLKBLK_RESET;
            pin_oe_n_o <= '1;
        end else begin
            state_q <= state_d;
            sh_q <= sh_d;
            beat_q <= beat_d;
            drv_q <= drv_d;
            ts_q <= ts_d;
            push_q <= push_d;
            hold_q <= hold_d;
            ev_q <= ev_d;
            ostb_q <= ostb_d;
            cnt_q <= cnt_d;
            sel_q <= cfg_i.clk_sel;
            pin_oe_n_o <= oe_n_d;
        end
    end

    assign cnt_o = cnt_q;
    assign tstamp_o = ts_q;
    assign event_o = ev_q;
    assign output_strobe_o = ostb_q;
    assign pin_o = cfg_i.open_coll ? '0 : drv_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    AST_CNT_WRAP: assert property (sel_tick && cnt_q == CNT_MAX |=> cnt_o == '0)
        else $error("counter did not wrap");
    AST_CNT_HOLD: assert property (!sel_tick |=> cnt_o == $past(cnt_o))
        else $error("counter moved without tick");
    AST_OC_NO_HIGH: assert property (cfg_i.open_coll |-> (~pin_oe_n_o & pin_o) == '0)
        else $error("open collector drove high");
    AST_IN_NO_DRIVE: assert property ((!cfg_i.dir_out)[*2] |-> &pin_oe_n_o)
        else $error("input port drives pins");
    AST_LINK_RELEASE: assert property (link_en_i |=> &(pin_oe_n_o | ~LINK_MASK))
        else $error("port drives link pins");
    AST_NARROW: assert property (1'b1 |=> &(pin_oe_n_o | ~$past(narrow_taken_i)))
        else $error("port drives taken pins");
    AST_TSTAMP: assert property (state_q == ST_SHIFT && beat_q == '0 && sel_tick
        && (cfg_i.dir_out || strobe_ok) |=> tstamp_o == $past(cnt_q))
        else $error("timestamp not captured");
    AST_TIMED: assert property (state_q == ST_WAIT_TIME && !time_ok && cfg_i.enable
        |=> state_q == ST_WAIT_TIME)
        else $error("timed transfer left early");
    AST_EVENT: assert property (event_o |-> $past(state_q) == ST_WAIT_COND
        && $past(cond_met))
        else $error("event without condition");
    AST_RESET_BLK: assert property ($rose(rstn_i) |-> sel_q == CLKBLK_RESET)
        else $error("not on clock block 0 after reset");

    COV_EVENT: cover property (event_o);
    COV_WRAP: cover property (sel_tick && cnt_q == CNT_MAX);
    COV_FULL: cover property (!f_wready);
    COV_STROBE: cover property (output_strobe_o ##1 output_strobe_o);

endmodule

// File: dv/iop_pin_model.sv
// Pin-side partner model of the programmable I/O port
`timescale 1ns/100ps
module iop_pin_model (
    // Clock
    input  wire logic clk_i,
    // Port pins
    input  wire logic [3:0] pad_i,
    input  wire logic [3:0] pad_oe_n_i,
    input  wire logic strobe_i,
    output logic [3:0] pad_o,
    output logic ext_clk_o,
    output logic strobe_o,
    // Bench control
    input  wire logic drive_en_i,
    input  wire logic [3:0] drive_val_i,
    input  wire logic strobe_val_i,
    input  wire logic ext_run_i
);
    logic [3:0] beats[$];
    logic [3:0] level;

    // ------------------------------------------------------------
    // Wire levels
    // ------------------------------------------------------------
    // Pull-up on every pin, so a released pin reads high
    assign level = pad_oe_n_i | pad_i;
    assign pad_o = drive_en_i ? drive_val_i : level;
    assign strobe_o = strobe_val_i;
    initial ext_clk_o = 1'b0;
    // Odd half period over two core cycles, so the pin filter keeps every level
    always #61 ext_clk_o = ext_run_i ? ~ext_clk_o : 1'b0;

    // ------------------------------------------------------------
    // Beat capture
    // ------------------------------------------------------------
    always @(posedge clk_i) begin
        if (strobe_i === 1'b1) begin
            beats.push_back(level);
        end
    end
endmodule

// File: dv/test_io_port_serdes_mux.sv
// Self-checking bench of the programmable I/O port
`timescale 1ns/100ps
module test_io_port_serdes_mux;
    import iop_pkg::*;
    typedef struct packed {
        logic [7:0] d;
        logic oc;
        logic [3:0] nt;
        logic ln;
        logic [7:0] e;
    } iop_row_t;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    iop_cfg_t cfg_i = '0;
    logic [3:0] cond_value_i = 4'h0;
    iop_clkblk_cfg_t [NUM_CLKBLK-1:0] clkblk_cfg_i = '0;
    logic link_en_i = 1'b0;
    logic [3:0] narrow_taken_i = 4'h0;
    logic out_valid_i = 1'b0;
    logic out_ready_o;
    logic [7:0] out_data_i = 8'h00;
    logic in_valid_o;
    logic in_ready_i = 1'b0;
    logic [7:0] in_data_o;
    logic [15:0] cnt_o;
    logic [15:0] tstamp_o;
    logic event_o;
    logic [3:0] pin_i;
    logic [3:0] pin_o;
    logic [3:0] pin_oe_n_o;
    logic ext_clk_i;
    logic input_strobe_i;
    logic output_strobe_o;
    logic drive_en = 1'b0;
    logic [3:0] drive_val = 4'h0;
    logic strobe_val = 1'b0;
    logic ext_run = 1'b0;
    int n_mismatch = 0;
    int n_tests = 0;
    int cycles = 0;
    int n_ev = 0;
    int e0;
    int acc;
    logic [15:0] t0;
    // Expected pin word: released and taken pins read high through the pull-ups
    iop_row_t rows[5] = '{
        '{8'h5a, 1'b0, 4'h0, 1'b0, 8'h5a}, '{8'hc3, 1'b1, 4'h0, 1'b0, 8'hc3},
        '{8'h96, 1'b0, 4'h3, 1'b0, 8'hb7}, '{8'h3c, 1'b1, 4'h8, 1'b0, 8'hbc},
        '{8'ha5, 1'b0, 4'h0, 1'b1, 8'hff}};

    iop_port dut_u (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .cfg_i(cfg_i),
        .cond_value_i(cond_value_i),
        .clkblk_cfg_i(clkblk_cfg_i),
        .link_en_i(link_en_i),
        .narrow_taken_i(narrow_taken_i),
        .out_valid_i(out_valid_i),
        .out_ready_o(out_ready_o),
        .out_data_i(out_data_i),
        .in_valid_o(in_valid_o),
        .in_ready_i(in_ready_i),
        .in_data_o(in_data_o),
        .cnt_o(cnt_o),
        .tstamp_o(tstamp_o),
        .event_o(event_o),
        .pin_i(pin_i),
        .pin_o(pin_o),
        .pin_oe_n_o(pin_oe_n_o),
        .ext_clk_i(ext_clk_i),
        .input_strobe_i(input_strobe_i),
        .output_strobe_o(output_strobe_o)
    );

    iop_pin_model model_u (
        .clk_i(clk_i),
        .pad_i(pin_o),
        .pad_oe_n_i(pin_oe_n_o),
        .strobe_i(output_strobe_o),
        .pad_o(pin_i),
        .ext_clk_o(ext_clk_i),
        .strobe_o(input_strobe_i),
        .drive_en_i(drive_en),
        .drive_val_i(drive_val),
        .strobe_val_i(strobe_val),
        .ext_run_i(ext_run)
    );

    // ------------------------------------------------------------
    // Clock, watchdog and helpers
    // ------------------------------------------------------------
    always #12.5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles++;
        if (event_o === 1'b1) n_ev++;
        // Whole run needs about 10000 cycles
        if (cycles == 60000) begin
            n_mismatch++;
            conclude();
        end
    end

    task automatic conclude();
        if (n_mismatch == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic put(input logic [7:0] d);
        out_data_i <= d;
        out_valid_i <= 1'b1;
        for (int i = 0; i < 300; i++) begin
            @(negedge clk_i);
            if (out_ready_o === 1'b1) break;
        end
        @(posedge clk_i);
        out_valid_i <= 1'b0;
    endtask

    task automatic wait_beats(input int n, input int lim);
        for (int i = 0; i < lim && model_u.beats.size() < n; i++) @(posedge clk_i);
    endtask

    task automatic chk_beat(input logic [3:0] exp);
        logic [3:0] b;
        b = 4'hx;
        if (model_u.beats.size() > 0) b = model_u.beats.pop_front();
        chk("pin beat", {12'h000, exp}, {12'h000, b});
    endtask

    task automatic get(input logic [7:0] exp);
        for (int i = 0; i < 200; i++) begin
            @(negedge clk_i);
            if (in_valid_o === 1'b1) break;
        end
        chk("in word", {7'h00, 1'b1, exp}, {7'h00, in_valid_o, in_data_o});
        @(posedge clk_i);
        in_ready_i <= 1'b1;
        @(posedge clk_i);
        in_ready_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic chk_rst();
        chk("oe_n", 16'h000f, {12'h000, pin_oe_n_o});
        chk("cnt", 16'h0000, cnt_o);
        chk("tstamp", 16'h0000, tstamp_o);
        chk("pulses", 16'h0000, {14'h0000, event_o, output_strobe_o});
    endtask

    // Flush the shared FIFO while disabled, then arm a sampling run
    task automatic arm(input iop_cond_t c, input logic [3:0] cv, input logic [3:0] pv,
            input logic [3:0] nt, input logic se);
        cfg_i.enable <= 1'b0;
        cfg_i.cond <= c;
        cfg_i.strobe_in_en <= se;
        cond_value_i <= cv;
        drive_val <= pv;
        narrow_taken_i <= nt;
        in_ready_i <= 1'b1;
        cyc(40);
        in_ready_i <= 1'b0;
        cfg_i.enable <= 1'b1;
        e0 = n_ev;
        t0 = cnt_o;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk_i);
        @(negedge clk_i);
        chk_rst();
        @(posedge clk_i);
        rstn_i <= 1'b1;
        cfg_i.enable <= 1'b1;
        cfg_i.dir_out <= 1'b1;
        cfg_i.strobe_out_en <= 1'b1;
        @(negedge clk_i);
        t0 = cnt_o;
        repeat (100) @(negedge clk_i);
        chk("cnt step", t0 + 16'h0064, cnt_o);
        foreach (rows[k]) begin
            @(posedge clk_i);
            cfg_i.open_coll <= rows[k].oc;
            narrow_taken_i <= rows[k].nt;
            link_en_i <= rows[k].ln;
            cyc(2);
            put(rows[k].d);
            wait_beats(2, 50);
            chk_beat(rows[k].e[3:0]);
            chk_beat(rows[k].e[7:4]);
        end
        @(negedge clk_i);
        t0 = cnt_o + 16'h0028;
        @(posedge clk_i);
        link_en_i <= 1'b0;
        narrow_taken_i <= 4'h0;
        cfg_i.open_coll <= 1'b0;
        cfg_i.timed <= 1'b1;
        cfg_i.target <= t0;
        put(8'h21);
        wait_beats(1, 100);
        chk("late beat", 16'h0001, 16'((cnt_o - t0) < 16'h0006 && cnt_o != t0));
        chk("late stamp", t0 + 16'h0001, tstamp_o);
        wait_beats(2, 20);
        model_u.beats.delete();
        // Strobe disabled: beats still drive but none are announced
        cfg_i.timed <= 1'b0;
        cfg_i.strobe_out_en <= 1'b0;
        put(8'h7e);
        cyc(10);
        chk("silent beats", 16'h0000, 16'(model_u.beats.size()));
        cfg_i.strobe_out_en <= 1'b1;
        // Slow drain so the FIFO must refuse
        cfg_i.timed <= 1'b0;
        cfg_i.clk_sel <= 3'h1;
        clkblk_cfg_i[1] <= '{1'b0, 8'hff};
        cyc(2);
        acc = 0;
        out_data_i <= 8'h00;
        out_valid_i <= 1'b1;
        for (int i = 0; i < 40; i++) begin
            @(negedge clk_i);
            if (out_ready_o !== 1'b1) break;
            acc++;
            @(posedge clk_i);
            out_data_i <= 8'(acc);
        end
        @(posedge clk_i);
        out_valid_i <= 1'b0;
        chk("fill", 16'h0001, 16'(acc >= FIFO_DEPTH && acc <= FIFO_DEPTH + 1));
        wait_beats(2 * acc, 20000);
        for (int j = 0; j < acc; j++) begin
            chk_beat(4'(j));
            chk_beat(4'(j >> 4));
        end
        cfg_i.dir_out <= 1'b0;
        cfg_i.clk_sel <= 3'h0;
        drive_en <= 1'b1;
        arm(COND_NEQ, 4'h9, 4'h9, 4'h0, 1'b0);
        cyc(30);
        chk("held off", 16'h0000, 16'(n_ev - e0) | {15'h0000, in_valid_o});
        cond_value_i <= 4'h3;
        get(8'h99);
        chk("event", 16'h0001, 16'(n_ev > e0));
        chk("stamp", 16'h0001, 16'(tstamp_o >= t0 && tstamp_o <= cnt_o));
        arm(COND_EQ, 4'h6, 4'h6, 4'h0, 1'b0);
        get(8'h66);
        chk("event", 16'h0001, 16'(n_ev > e0));
        arm(COND_NONE, 4'h0, 4'hd, 4'h3, 1'b1);
        cyc(30);
        chk("no strobe", 16'h0000, {15'h0000, in_valid_o});
        strobe_val <= 1'b1;
        get(8'hcc);
        cfg_i.clk_sel <= 3'h2;
        clkblk_cfg_i[2] <= '{1'b1, 8'h01};
        ext_run <= 1'b1;
        cyc(20);
        @(negedge clk_i);
        t0 = cnt_o;
        // 976 core cycles hold 200 pin clock rises, so 100 ticks
        repeat (976) @(negedge clk_i);
        chk("ext ticks", 16'h0001, 16'((cnt_o - t0) >= 98 && (cnt_o - t0) <= 102));
        @(posedge clk_i);
        rstn_i <= 1'b0;
        cfg_i.clk_sel <= 3'h0;
        @(negedge clk_i);
        chk_rst();
        @(posedge clk_i);
        rstn_i <= 1'b1;
        cyc(2);
        conclude();
    end
endmodule
